// [adc_output_port.sv]
// Parallel output port, conversion timing, readback and power-down of the converter
// Operation
// - Output word is result plus three address echo bits and differential flag.
// - Data drivers enabled only while read strobe and chip select are low.
// - Polarity low gives straight binary, step full scale over 4096 or 1024.
// - Polarity high gives two's complement, step span over 4096 or 1024.
// - In readback the top three result pins carry status bits.
// - In readback a 7-bit status word shows while read strobe and chip select are low.
// - In readback the lower result pins stay high impedance always.
// - Conversions are timed from the internal clock only.
// - Conversion takes about 1400 ns and at most 2 us.
// - Acquisition finishes within 150 ns before conversion may begin.
// - A full conversion cycle every 2.5 us, at least 400 ksps.
// - Device is powered down while shutdown input is held low.
// - Chip select low at shutdown selects nap, high selects sleep.
// - Nap keeps digital logic and reference powered; digital state survives.
// - Busy is low for the whole conversion, high when it completes.
// - Start requests are ignored while a conversion is in progress.
// - Readback mode pins hold busy low and block conversions.
module adc_output_port
  import adc_port_pkg::*;
#(
  parameter int RES_W = RES_W_12
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    chip_select_n_in,
  input  wire logic                    read_n_in,
  input  wire logic                    convert_start_n_in,
  input  wire logic                    power_down_n_in,
  input  wire logic                    polarity_select_in,
  input  wire logic                    mode_pin_high_in,
  input  wire logic                    mode_pin_low_in,
  input  wire logic [2:0]              mux_addr_in,
  input  wire logic                    diff_in,
  input  wire logic [RES_W-1:0]        sample_in,
  input  wire logic [STATUS_W-1:0]     readback_status_word_in,
  output logic      [RES_W-1:0]        data_out,
  output logic      [RES_W-1:0]        data_oe_out,
  output logic      [ECHO_W-1:0]       addr_echo_out,
  output logic                         addr_echo_oe_out,
  output logic                         busy_n_out,
  output logic                         napping_out,
  output logic                         sleeping_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} conv_state_t;

  localparam int LOW_PINS = RES_W - STATUS_PINS;

  // Only the two documented resolutions are served
  if (RES_W != RES_W_12 && RES_W != RES_W_10) begin : g_bad_width
    $error("RES_W must be 10 or 12");
  end

  conv_state_t             state_ff;
  logic [CNT_W-1:0]        cnt_ff;
  logic                    start_n_d_ff;
  logic [RES_W-1:0]        result_ff;
  logic [ECHO_W-1:0]       echo_ff;
  logic [ECHO_W-1:0]       pend_echo_ff;
  logic                    asleep_ff;
  logic                    pol_ff;
  logic [RES_W-1:0]        code;
  logic                    readback;
  logic                    powered;
  logic                    start_req;
  logic                    read_en;

  adc_code_format #(
    .RES_W (RES_W)
  ) u_code (
    .sample_in          (sample_in),
    .polarity_select_in (pol_ff),
    .code_out           (code)
  );

  // Decode of mode, power and request terms
  assign readback  = ({mode_pin_high_in, mode_pin_low_in} == MODE_READBACK);
  assign powered   = power_down_n_in;
  assign read_en   = !read_n_in && !chip_select_n_in;
  // Falling edge of start with chip selected
  assign start_req = start_n_d_ff && !convert_start_n_in && !chip_select_n_in;

  // Start pin history for edge detection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_n_d_ff <= 1'b1;
    end else begin
      start_n_d_ff <= convert_start_n_in;
    end
  end

  // Conversion sequencer on the internal clock; no external clock needed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= '0;
      pend_echo_ff <= '0;
      pol_ff       <= 1'b0;
    end else if (!powered) begin
      // Shutdown aborts any conversion in flight
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // Readback blocks conversions
          if (start_req && !readback) begin
            state_ff     <= ST_ACQ;
            cnt_ff       <= CNT_W'(ACQ_CYCLES - 1);
            pend_echo_ff <= {diff_in, mux_addr_in};
            pol_ff       <= polarity_select_in;
          end
        end
        ST_ACQ: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_CONV;
            cnt_ff   <= CNT_W'(CONV_CYCLES - 1);
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_CONV: begin
          // Further starts are ignored until done
          if (cnt_ff == '0) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Result and echo update together at completion only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_ff <= RESULT_RST[RES_W-1:0];
      echo_ff   <= '0;
    end else if (powered && state_ff == ST_CONV && cnt_ff == '0) begin
      result_ff <= code;
      echo_ff   <= pend_echo_ff;
    end
  end

  // Busy low during conversion and throughout readback
  // Held low through the completion edge so busy rises with the new data on the pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_n_out <= 1'b1;
    end else begin
      busy_n_out <= !(readback || (powered && start_req && state_ff == ST_IDLE)
                      || (powered && state_ff != ST_IDLE));
    end
  end

  // Shutdown kind latched from chip select as shutdown falls
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      asleep_ff <= 1'b0;
    end else if (powered) begin
      asleep_ff <= chip_select_n_in;
    end
  end

  // Power state flags; nap keeps registers, so results survive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      napping_out  <= 1'b0;
      sleeping_out <= 1'b0;
    end else begin
      napping_out  <= !powered && !(powered ? chip_select_n_in : asleep_ff);
      sleeping_out <= !powered && (powered ? chip_select_n_in : asleep_ff);
    end
  end

  // Output pins: result or readback status, enables registered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_out         <= '0;
      data_oe_out      <= '0;
      addr_echo_out    <= '0;
      addr_echo_oe_out <= 1'b0;
    end else if (readback) begin
      // Status on top pins; low pins stay released
      data_out <= {readback_status_word_in[STATUS_PINS-1:0], {LOW_PINS{1'b0}}};
      data_oe_out <= {{STATUS_PINS{read_en}}, {LOW_PINS{1'b0}}};
      addr_echo_out    <= readback_status_word_in[STATUS_W-1:STATUS_PINS];
      addr_echo_oe_out <= read_en;
    end else begin
      data_out         <= result_ff;
      data_oe_out      <= {RES_W{read_en}};
      addr_echo_out    <= echo_ff;
      addr_echo_oe_out <= read_en;
    end
  end
endmodule

// [adc_port_pkg.sv]
// Package of widths, timing figures and cycle counts for the converter output port
package adc_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Conversion, acquisition, throughput and wake time figures in ns; sleep wake in ms
  localparam int CONV_TYP_NS = 1400;
  localparam int CONV_MAX_NS = 2000;
  localparam int ACQ_MAX_NS = 150;
  localparam int THROUGHPUT_NS = 2500;
  localparam int NAP_WAKE_NS = 200;
  localparam int SLEEP_WAKE_MS = 10;
  // Typical conversion, rounded down so the 2 us limit holds
  localparam int CONV_CYCLES = CONV_TYP_NS / CLK_PERIOD_NS;
  // Acquisition is a longest time: round down, at least one cycle
  localparam int ACQ_CYCLES = (ACQ_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : ACQ_MAX_NS / CLK_PERIOD_NS;
  localparam int THRU_CYCLES = THROUGHPUT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  // Width of the readback status word
  localparam int STATUS_W = 7;
  localparam int STATUS_PINS = 3;
  localparam int ECHO_W = 4;
  // Width of the full-scale result of the 12-bit part
  localparam int RES_W_12 = 12;
  localparam int RES_W_10 = 10;
  // Mode pin encodings: readback is high pin set, low pin clear
  localparam logic [1:0] MODE_READBACK = 2'h2;
  // Reset value of the held result
  localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage

// [adc_code_format.sv]
// Result coder: straight binary or two's complement from an offset-binary sample
module adc_code_format
  import adc_port_pkg::*;
#(
  parameter int RES_W = RES_W_12
) (
  input  wire logic [RES_W-1:0] sample_in,
  input  wire logic             polarity_select_in,
  output logic      [RES_W-1:0] code_out
);
  // Bipolar flips the top bit; unipolar passes through
  always_comb begin
    code_out = sample_in;
    if (polarity_select_in) begin
      code_out[RES_W-1] = ~sample_in[RES_W-1];
    end
  end
endmodule

// [adc_port_checker.sv]
// Concurrent checks on the converter output port
module adc_port_checker
  import adc_port_pkg::*;
#(
  parameter int RES_W = RES_W_12
) (
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic                chip_select_n_in,
  input wire logic                read_n_in,
  input wire logic                convert_start_n_in,
  input wire logic                power_down_n_in,
  input wire logic                mode_pin_high_in,
  input wire logic                mode_pin_low_in,
  input wire logic [2:0]          mux_addr_in,
  input wire logic                diff_in,
  input wire logic [STATUS_W-1:0] readback_status_word_in,
  input wire logic [RES_W-1:0]    data_out,
  input wire logic [RES_W-1:0]    data_oe_out,
  input wire logic [ECHO_W-1:0]   addr_echo_out,
  input wire logic                addr_echo_oe_out,
  input wire logic                busy_n_out,
  input wire logic                napping_out,
  input wire logic                sleeping_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic rb = mode_pin_high_in && !mode_pin_low_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Start accepted only when selected, powered, idle
  sequence s_take;
    $fell(convert_start_n_in) && !chip_select_n_in && power_down_n_in && !rb && busy_n_out;
  endsequence
  sequence s_quiet;
    busy_n_out && !rb;
  endsequence
  // Shutdown aborts, so it cancels the timing check
  property p_conv;
    @(posedge clk_in) disable iff (!rst_n_in || !power_down_n_in)
      s_take |-> ##1 !busy_n_out ##155 !busy_n_out ##1
        (busy_n_out && addr_echo_out == $past({diff_in, mux_addr_in}, 157));
  endproperty
  property p_off;
    (read_n_in || chip_select_n_in) |=> (data_oe_out == '0 && !addr_echo_oe_out);
  endproperty
  property p_on;
    (!read_n_in && !chip_select_n_in && !rb) |=> (&data_oe_out && addr_echo_oe_out);
  endproperty
  property p_rb_low;
    rb |=> (data_oe_out[RES_W-4:0] == '0 && !busy_n_out);
  endproperty
  property p_rb_stat;
    (rb && !read_n_in && !chip_select_n_in) |=> (&data_oe_out[RES_W-1 -: 3] &&
      data_out[RES_W-1 -: 3] == $past(readback_status_word_in[2:0]) &&
      addr_echo_out == $past(readback_status_word_in[6:3]));
  endproperty
  property p_hold;
    s_quiet ##1 s_quiet ##1 s_quiet |-> ($stable(data_out) && $stable(addr_echo_out));
  endproperty
  property p_nap;
    $fell(power_down_n_in) |=> (napping_out == !$past(chip_select_n_in, 2) &&
      sleeping_out == $past(chip_select_n_in, 2));
  endproperty
  property p_wake;
    power_down_n_in |=> (!napping_out && !sleeping_out);
  endproperty
  a_conv: assert property (p_conv) else $error("conversion timing or echo wrong");
  a_off: assert property (p_off) else $error("drivers on while not read");
  a_on: assert property (p_on) else $error("drivers off during read");
  a_rb_low: assert property (p_rb_low) else $error("readback low pins or busy");
  a_rb_stat: assert property (p_rb_stat) else $error("readback status wrong");
  a_hold: assert property (p_hold) else $error("result changed while idle");
  a_nap: assert property (p_nap) else $error("shutdown kind wrong");
  a_wake: assert property (p_wake) else $error("shutdown flag while powered");
endmodule

bind adc_output_port adc_port_checker #(.RES_W(RES_W)) i_chk (.*);

// [host_model.sv]
// Host processor model driving the converter strobes
module host_model
  import adc_port_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic busy_n_in,
  output logic      cs_n_out,
  output logic      rd_n_out,
  output logic      start_n_out,
  output logic      pd_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    start_n_out = 1'b1;
    pd_n_out = 1'b1;
  end
  task automatic strobe(input logic cs, input logic rd);
    @(posedge clk_in);
    cs_n_out <= cs;
    rd_n_out <= rd;
  endtask
  // Start, poke again while busy, then hold off the bus until done
  task automatic convert();
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    start_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    start_n_out <= 1'b1;
    repeat (20) @(posedge clk_in);
    start_n_out <= 1'b0;
    @(posedge clk_in);
    start_n_out <= 1'b1;
    for (int i = 0; i < 300 && busy_n_in !== 1'b1; i++) @(posedge clk_in);
  endtask
  // Chip select is set by strobe beforehand; wake waits out the nap delay
  task automatic power(input logic pd);
    @(posedge clk_in);
    pd_n_out <= pd;
    if (pd) repeat (NAP_WAKE_NS / CLK_PERIOD_NS) @(posedge clk_in);
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the converter output port
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_n_in, pol, m_hi, m_lo, dif, cs_n, rd_n, st_n, pd_n;
  logic [2:0]  mux;
  logic [11:0] smp, dout, doe, last;
  logic [6:0]  stat;
  logic [3:0]  echo;
  logic        echo_oe, busy_n, nap, slp;
  int          errors = 0;
  int          checked = 0;
  adc_output_port #(.RES_W(12)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .chip_select_n_in(cs_n), .read_n_in(rd_n), .convert_start_n_in(st_n),
    .power_down_n_in(pd_n), .polarity_select_in(pol), .mode_pin_high_in(m_hi),
    .mode_pin_low_in(m_lo), .mux_addr_in(mux), .diff_in(dif), .sample_in(smp),
    .readback_status_word_in(stat), .data_out(dout), .data_oe_out(doe),
    .addr_echo_out(echo), .addr_echo_oe_out(echo_oe), .busy_n_out(busy_n),
    .napping_out(nap), .sleeping_out(slp));
  host_model i_host (.clk_in(clk_in), .busy_n_in(busy_n), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .start_n_out(st_n), .pd_n_out(pd_n));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Convert one sample and read it back over the bus
  // Expected code is given by the caller from the coding rules
  task automatic t_conv(input logic p, input logic [2:0] a, input logic d,
                        input logic [11:0] s, input logic [11:0] e);
    @(posedge clk_in);
    pol <= p;
    mux <= a;
    dif <= d;
    smp <= s;
    i_host.convert();
    i_host.strobe(1'b0, 1'b0);
    repeat (2) @(posedge clk_in);
    last = e;
    `CHK("result", last, dout)
    `CHK("echo", {d, a}, echo)
    i_host.strobe(1'b1, 1'b1);
  endtask
  // Readback mode shows status on top pins and echo pins only
  task automatic t_readback();
    @(posedge clk_in);
    m_hi <= 1'b1;
    stat <= 7'h5a;
    i_host.strobe(1'b0, 1'b0);
    repeat (3) @(posedge clk_in);
    `CHK("status top", 3'h2, dout[11:9])
    `CHK("status echo", 4'hb, echo)
    `CHK("rb enables", 12'he00, doe)
    `CHK("rb busy", 1'b0, busy_n)
    i_host.strobe(1'b1, 1'b1);
    m_hi <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // Chip select level picks nap or sleep; result survives
  task automatic t_power(input logic cs);
    i_host.strobe(cs, 1'b1);
    i_host.power(1'b0);
    repeat (3) @(posedge clk_in);
    `CHK("nap", ~cs, nap)
    `CHK("sleep", cs, slp)
    i_host.power(1'b1);
    `CHK("kept", last, dout)
  endtask
  initial begin
    {pol, m_hi, m_lo, dif, mux, smp, stat} = '0;
    rst_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    `CHK("busy rst", 1'b1, busy_n)
    // Mid-scale unipolar, mid-scale bipolar is zero, one below mid-scale is minus one
    t_conv(1'b0, 3'h5, 1'b0, 12'h800, 12'h800);
    t_conv(1'b1, 3'h2, 1'b1, 12'h800, 12'h000);
    t_conv(1'b1, 3'h7, 1'b1, 12'h7ff, 12'hfff);
    t_readback();
    t_power(1'b0);
    // Sleep wake comes last: no conversion is judged before the reference settles
    t_power(1'b1);
    conclude();
  end
  // Run needs about 560 cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    conclude();
  end
endmodule
